/* File: acoh_pkg.sv */
// constants, carrier types and character helpers for the command handler
// assumes ASCII characters delivered one per clock by an external receiver
package acoh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog timing
  localparam int CLK_MHZ         = 40;
  localparam int WD_UNIT_US_GEN1 = 53300;   // watchdog unit in us, generation 1
  localparam int WD_UNIT_US_GEN2 = 100000;  // watchdog unit in us, generation 2

  ////////////////////////////////////////////////////////////////////////////
  // buffer sizes and command lengths (leading char, address, function, ...)
  localparam int         MAXC          = 19;
  localparam logic [4:0] LEN_BCAST     = 5'h03;
  localparam logic [4:0] LEN_BASE      = 5'h04;
  localparam logic [4:0] LEN_TRIM      = 5'h06;
  localparam logic [4:0] LEN_LEAD_SET  = 5'h0B;

  ////////////////////////////////////////////////////////////////////////////
  // characters
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_ACK  = 8'h21;
  localparam logic [7:0] CH_NAK  = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_0    = 8'h30;
  localparam logic [7:0] CH_1    = 8'h31;
  localparam logic [7:0] CH_9    = 8'h39;
  localparam logic [7:0] CH_A    = 8'h41;
  localparam logic [7:0] CH_D    = 8'h44;
  localparam logic [7:0] CH_F    = 8'h46;
  localparam logic [7:0] HEX_LO  = 8'h30;   // '0' - 0
  localparam logic [7:0] HEX_HI  = 8'h37;   // 'A' - 10

  // function characters
  localparam logic [7:0] FN_CAL20    = 8'h31;
  localparam logic [7:0] FN_TRIM     = 8'h33;
  localparam logic [7:0] FN_SAVE     = 8'h34;
  localparam logic [7:0] FN_LAST     = 8'h36;
  localparam logic [7:0] FN_CURR     = 8'h38;
  localparam logic [7:0] FN_LEAD_RD  = 8'h30;
  localparam logic [7:0] FN_LEAD_SET = 8'h31;
  localparam logic [7:0] FN_WD_SET   = 8'h32;
  localparam logic [7:0] FN_WD_RD    = 8'h33;

  // default leading codes, index 0 is the read class: $ # % @ ~ *
  localparam logic [5:0][7:0] LEAD_DEFAULT =
    {8'h2A, 8'h7E, 8'h40, 8'h25, 8'h23, 8'h24};

  ////////////////////////////////////////////////////////////////////////////
  // trim window, level range, status bit positions
  localparam logic [7:0]  TRIM_UP_MAX = 8'h5F;
  localparam logic [7:0]  TRIM_DN_MIN = 8'hA1;
  localparam logic [11:0] LEVEL_MAX   = 12'hFFF;
  localparam int          STB_PWR     = 1;
  localparam int          STB_WD_EN   = 2;
  localparam int          STB_HOST    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } acoh_char_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    logic [11:0] level;
  } acoh_ao_t;

  typedef struct packed {
    logic        wr;
    logic [11:0] level;
  } acoh_nvm_t;

  ////////////////////////////////////////////////////////////////////////////
  // hex digit decode: bit 4 flags a legal upper-case digit
  function automatic logic [4:0] hex_dec(input logic [7:0] c);
    if (c >= CH_0 && c <= CH_9)
      return {1'b1, c[3:0]};
    if (c >= CH_A && c <= CH_F)
      return {1'b1, 4'(c[3:0] + 4'h9)};
    return 5'h00;
  endfunction : hex_dec

  // nibble to upper-case hex character
  function automatic logic [7:0] hex_enc(input logic [3:0] v);
    return (v < 4'hA) ? HEX_LO + {4'h0, v} : HEX_HI + {4'h0, v};
  endfunction : hex_enc

endpackage : acoh_pkg

/* File: acoh_wdog.sv */
// host watchdog: counts timeout units, latches a host failure on expiry
// assumes restart pulses come from the handler on the same clock
module acoh_wdog #(
  parameter int UNIT_CYC = 4000000
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // control
  input  wire logic       enable,
  input  wire logic [7:0] timeout,
  input  wire logic       restart,
  // status
  output logic            fail_r
);
  import acoh_pkg::*;

  localparam int PW = $clog2(UNIT_CYC + 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [7:0]    units;
    logic          fail;
  } acoh_wd_state_t;

  acoh_wd_state_t s_r;
  acoh_wd_state_t s_nxt;
  logic           expire;

  if (UNIT_CYC < 1)
  begin : g_bad_unit
    $error("UNIT_CYC must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // unit prescaler and unit counter; expiry beats a restart in the same cycle
  assign expire = enable && !s_r.fail && s_r.pre == PW'(UNIT_CYC - 1)
                  && (s_r.units + 8'h01) == timeout;

  always_comb
  begin
    s_nxt = s_r;
    if (restart || !enable)
    begin
      s_nxt.pre   = '0;
      s_nxt.units = '0;
    end
    else if (!s_r.fail)
    begin
      if (s_r.pre == PW'(UNIT_CYC - 1))
      begin
        s_nxt.pre   = '0;
        s_nxt.units = s_r.units + 8'h01;
      end
      else
        s_nxt.pre = s_r.pre + PW'(1);
    end
    s_nxt.fail = expire || (s_r.fail && !restart);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign fail_r = s_r.fail;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_wd_expiry;
    @(posedge clk) disable iff (!resetn)
    $rose(fail_r) |-> $past(enable) && ($past(s_r.units) + 8'h01) == $past(timeout);
  endproperty
  a_wd_expiry: assert property (p_wd_expiry)
    else $error("host failure without a full timeout");

endmodule : acoh_wdog

/* File: acoh_handler.sv */
// command handler: parses framed commands, answers, keeps output levels
// assumes a receiver and transmitter on clk exchange one character at a time
module acoh_handler #(
  parameter int NUM_PORTS   = 1,
  parameter int FW_GEN      = 2,
  parameter int WD_UNIT_CYC = (FW_GEN == 1 ? acoh_pkg::WD_UNIT_US_GEN1
                              : acoh_pkg::WD_UNIT_US_GEN2) * acoh_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // command characters
  input  acoh_pkg::acoh_char_t      rx_char,
  output acoh_pkg::acoh_char_t      tx_char,
  input  wire logic                 tx_ready,
  // module setup
  input  wire logic [7:0]           my_addr,
  input  wire logic                 pwr_wd_fail,
  // analog output path
  input  acoh_pkg::acoh_ao_t        ao_write,
  input  wire logic [11:0]          est_current,
  input  wire logic [11:0]          power_on_level,
  output logic [3:0][11:0]          out_level,
  output logic                      cal20_store,
  output acoh_pkg::acoh_nvm_t       nvm_save,
  output logic                      host_fail
);
  import acoh_pkg::*;

  localparam logic [4:0] LEN_RB     = 5'(4 + (NUM_PORTS == 4 ? 1 : 0));
  localparam logic [4:0] LEN_WD_SET = 5'(7 + 3 * NUM_PORTS);

  if (NUM_PORTS != 1 && NUM_PORTS != 4)
  begin : g_bad_ports
    $error("NUM_PORTS must be 1 or 4");
  end

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RX   = 2'b01,
    ST_EXEC = 2'b10,
    ST_TX   = 2'b11
  } acoh_st_t;

  typedef struct packed {
    acoh_st_t             st;
    logic [4:0]           len, tlen, tidx;
    logic [MAXC-1:0][7:0] rx, tx;
    logic [5:0][7:0]      lead;
    logic                 wd_en;
    logic [7:0]           wd_tmo;
    logic [3:0][11:0]     safe, last, lvl;
    logic                 wd_load, kick, cal20;
    acoh_char_t           txo;
    acoh_nvm_t            nvm;
  } acoh_state_t;

  acoh_state_t s_r;
  acoh_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the buffered command
  logic [4:0]  a_hi, a_lo, t_hi, t_lo;
  logic [7:0]  pair;
  logic        cls1, cls5, bcast, mine, trim_cmd, trim_ok;
  logic [12:0] tr_up, tr_dn;
  logic [11:0] trimmed;

  assign a_hi     = hex_dec(s_r.rx[1]);
  assign a_lo     = hex_dec(s_r.rx[2]);
  assign t_hi     = hex_dec(s_r.rx[4]);
  assign t_lo     = hex_dec(s_r.rx[5]);
  assign pair     = {t_hi[3:0], t_lo[3:0]};
  assign cls1     = s_r.rx[0] == s_r.lead[0];
  assign cls5     = s_r.rx[0] == s_r.lead[4];
  assign bcast    = cls5 && s_r.rx[1] == CH_STAR && s_r.rx[2] == CH_STAR
                    && s_r.len == LEN_BCAST;
  assign mine     = (cls1 || cls5) && !bcast && a_hi[4] && a_lo[4] && s_r.len >= LEN_BCAST
                    && {a_hi[3:0], a_lo[3:0]} == my_addr;
  assign trim_cmd = mine && cls1 && s_r.rx[3] == FN_TRIM && s_r.len == LEN_TRIM
                    && t_hi[4] && t_lo[4];
  assign trim_ok  = trim_cmd && (pair <= TRIM_UP_MAX || pair >= TRIM_DN_MIN);

  // trim arithmetic, clamped to the level range
  assign tr_up   = {1'b0, s_r.last[0]} + {5'h00, pair};
  assign tr_dn   = {1'b0, s_r.last[0]} - {5'h00, 8'(8'h00 - pair)};
  assign trimmed = (pair <= TRIM_UP_MAX) ? (tr_up[12] ? LEVEL_MAX : tr_up[11:0])
                                         : (tr_dn[12] ? 12'h000 : tr_dn[11:0]);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [4:0]       k;
    logic             ok;
    logic             bad;
    logic [1:0]       sel;
    logic [11:0]      sv;
    logic [4:0]       hx;
    logic [3:0]       stat;
    logic [7:0]       tmo;
    logic [3:0][11:0] sa;
    k    = 5'h03;
    ok   = 1'b0;
    bad  = 1'b0;
    sel  = 2'h0;
    sv   = 12'h000;
    hx   = 5'h00;
    stat = 4'h0;
    tmo  = 8'h00;
    sa   = s_r.safe;
    s_nxt = s_r;
    s_nxt.cal20   = 1'b0;
    s_nxt.nvm.wr  = 1'b0;
    s_nxt.kick    = 1'b0;
    s_nxt.wd_load = 1'b0;
    for (int i = 0; i < 4; i++)
      s_nxt.lvl[i] = host_fail ? s_r.safe[i] : s_r.last[i];
    if (ao_write.valid)
      s_nxt.last[ao_write.port] = ao_write.level;
    unique case (s_r.st)
      ST_BOOT:
      begin
        for (int i = 0; i < 4; i++)
          s_nxt.last[i] = power_on_level;
        s_nxt.st = ST_RX;
      end
      ST_RX:
      begin
        if (rx_char.valid)
        begin
          if (rx_char.data == CH_CR)
            s_nxt.st = ST_EXEC;
          else if (s_r.len != 5'(MAXC))
          begin
            s_nxt.rx[s_r.len] = rx_char.data;
            s_nxt.len = s_r.len + 5'h01;
          end
        end
      end
      ST_EXEC:
      begin
        s_nxt.len   = '0;
        s_nxt.st    = ST_RX;
        s_nxt.tidx  = '0;
        s_nxt.tx[0] = CH_ACK;
        s_nxt.tx[1] = s_r.rx[1];
        s_nxt.tx[2] = s_r.rx[2];
        if (bcast)
          s_nxt.kick = 1'b1;
        else if (mine)
        begin
          s_nxt.st = ST_TX;
          if (cls1)
          begin
            case (s_r.rx[3])
              FN_CAL20:
              begin
                ok = s_r.len == LEN_BASE;
                s_nxt.cal20 = ok;
              end
              FN_TRIM:
              begin
                ok = trim_ok;
                if (ok)
                  s_nxt.last[0] = trimmed;
              end
              FN_SAVE:
              begin
                ok = s_r.len == LEN_BASE;
                s_nxt.nvm.wr    = ok;
                s_nxt.nvm.level = s_r.lvl[0];
              end
              FN_LAST:
              begin
                if (NUM_PORTS == 4)
                  sel = 2'(s_r.rx[4] - CH_A);
                ok = s_r.len == LEN_RB && (NUM_PORTS == 1
                     || (s_r.rx[4] >= CH_A && s_r.rx[4] <= CH_D));
                sv = s_r.last[sel];
              end
              FN_CURR:
              begin
                ok = s_r.len == LEN_BASE;
                sv = est_current;
              end
              default: ok = 1'b0;
            endcase
            if (ok && (s_r.rx[3] == FN_LAST || s_r.rx[3] == FN_CURR))
              for (int d = 0; d < 3; d++)
              begin
                s_nxt.tx[k] = hex_enc(4'(sv >> (8 - 4 * d)));
                k = k + 5'h01;
              end
          end
          else
          begin
            case (s_r.rx[3])
              FN_LEAD_RD:
              begin
                ok = s_r.len == LEN_BASE;
                stat[STB_PWR]   = pwr_wd_fail;
                stat[STB_WD_EN] = s_r.wd_en;
                stat[STB_HOST]  = host_fail;
                s_nxt.tx[k] = hex_enc(4'h0);
                k = k + 5'h01;
                s_nxt.tx[k] = hex_enc(stat);
                k = k + 5'h01;
                for (int j = 0; j < 6; j++)
                begin
                  s_nxt.tx[k] = s_r.lead[j];
                  k = k + 5'h01;
                end
              end
              FN_LEAD_SET:
              begin
                ok = s_r.len == LEN_LEAD_SET && s_r.rx[4] == CH_0;
                if (ok)
                  for (int j = 0; j < 6; j++)
                    s_nxt.lead[j] = s_r.rx[5 + j];
              end
              FN_WD_SET:
              begin
                bad = s_r.len != LEN_WD_SET
                      || (s_r.rx[4] != CH_0 && s_r.rx[4] != CH_1);
                for (int d = 0; d < 2; d++)
                begin
                  hx  = hex_dec(s_r.rx[5 + d]);
                  bad = bad || !hx[4];
                  tmo = {tmo[3:0], hx[3:0]};
                end
                bad = bad || tmo == 8'h00;
                for (int i = 0; i < NUM_PORTS; i++)
                  for (int d = 0; d < 3; d++)
                  begin
                    hx    = hex_dec(s_r.rx[7 + 3 * i + d]);
                    bad   = bad || !hx[4];
                    sa[i] = {sa[i][7:0], hx[3:0]};
                  end
                ok = !bad;
                if (ok)
                begin
                  s_nxt.wd_en   = s_r.rx[4] == CH_1;
                  s_nxt.wd_tmo  = tmo;
                  s_nxt.safe    = sa;
                  s_nxt.wd_load = 1'b1;
                end
              end
              FN_WD_RD:
              begin
                ok = s_r.len == LEN_BASE;
                s_nxt.tx[k] = s_r.wd_en ? CH_1 : CH_0;
                k = k + 5'h01;
                s_nxt.tx[k] = hex_enc(s_r.wd_tmo[7:4]);
                k = k + 5'h01;
                s_nxt.tx[k] = hex_enc(s_r.wd_tmo[3:0]);
                k = k + 5'h01;
                for (int i = 0; i < NUM_PORTS; i++)
                  for (int d = 0; d < 3; d++)
                  begin
                    s_nxt.tx[k] = hex_enc(4'(s_r.safe[i] >> (8 - 4 * d)));
                    k = k + 5'h01;
                  end
              end
              default: ok = 1'b0;
            endcase
          end
          if (!ok)
          begin
            s_nxt.tx[0] = CH_NAK;
            k = 5'h03;
          end
          s_nxt.tx[k] = CH_CR;
          s_nxt.tlen  = k + 5'h01;
        end
      end
      ST_TX:
      begin
        if (!s_r.txo.valid || tx_ready)
        begin
          if (s_r.tidx == s_r.tlen)
          begin
            s_nxt.txo.valid = 1'b0;
            s_nxt.st = ST_RX;
          end
          else
          begin
            s_nxt.txo.valid = 1'b1;
            s_nxt.txo.data  = s_r.tx[s_r.tidx];
            s_nxt.tidx = s_r.tidx + 5'h01;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_r      <= '0;
      s_r.lead <= LEAD_DEFAULT;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // host watchdog and outputs
  acoh_wdog #(
    .UNIT_CYC (WD_UNIT_CYC)
  ) u_wdog (
    .clk     (clk),
    .resetn  (resetn),
    .enable  (s_r.wd_en),
    .timeout (s_r.wd_tmo),
    .restart (s_r.wd_load | s_r.kick),
    .fail_r  (host_fail)
  );

  assign tx_char     = s_r.txo;
  assign out_level   = s_r.lvl;
  assign cal20_store = s_r.cal20;
  assign nvm_save    = s_r.nvm;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reply_lead;
    (s_r.st == ST_EXEC && mine) |=> ##1 tx_char.valid
      && (tx_char.data == CH_ACK || tx_char.data == CH_NAK);
  endproperty
  a_reply_lead: assert property (p_reply_lead)
    else $error("reply does not open with ! or ?");

  property p_ignore;
    (s_r.st == ST_EXEC && !mine) |=> s_r.st == ST_RX && !tx_char.valid;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("foreign or broadcast command got a reply");

  property p_alive;
    (s_r.st == ST_EXEC && bcast) |=> s_r.kick ##1 !s_r.kick;
  endproperty
  a_alive: assert property (p_alive)
    else $error("host alive did not restart the watchdog");

  property p_trim_up;
    (s_r.st == ST_EXEC && trim_ok && pair <= TRIM_UP_MAX)
      |=> s_r.last[0] >= $past(s_r.last[0]) && s_r.tx[0] == CH_ACK;
  endproperty
  a_trim_up: assert property (p_trim_up)
    else $error("upward trim lowered the output");

  property p_trim_dn;
    (s_r.st == ST_EXEC && trim_ok && pair >= TRIM_DN_MIN)
      |=> s_r.last[0] <= $past(s_r.last[0]) && s_r.tx[0] == CH_ACK;
  endproperty
  a_trim_dn: assert property (p_trim_dn)
    else $error("downward trim raised the output");

  property p_trim_rej;
    (s_r.st == ST_EXEC && trim_cmd && !trim_ok && !ao_write.valid)
      |=> s_r.tx[0] == CH_NAK && s_r.last[0] == $past(s_r.last[0]);
  endproperty
  a_trim_rej: assert property (p_trim_rej)
    else $error("out-of-range trim was not rejected");

  property p_lead_set;
    (s_r.st == ST_EXEC && mine && !cls1 && s_r.rx[3] == FN_LEAD_SET
      && s_r.len == LEN_LEAD_SET && s_r.rx[4] == CH_0)
      |=> s_r.lead[4] == $past(s_r.rx[9]) && s_r.tx[0] == CH_ACK;
  endproperty
  a_lead_set: assert property (p_lead_set)
    else $error("leading codes not replaced");

  property p_safe_out;
    host_fail |=> out_level[0] == $past(s_r.safe[0]);
  endproperty
  a_safe_out: assert property (p_safe_out)
    else $error("output not at failsafe level after host failure");

  property p_boot;
    s_r.st == ST_BOOT |=> s_r.last[0] == $past(power_on_level);
  endproperty
  a_boot: assert property (p_boot)
    else $error("start-up level not taken from storage");

  property p_cal20;
    cal20_store |=> tx_char.valid && tx_char.data == CH_ACK;
  endproperty
  a_cal20: assert property (p_cal20)
    else $error("calibration store not acknowledged");

  property p_nvm;
    nvm_save.wr |-> nvm_save.level == $past(s_r.lvl[0]);
  endproperty
  a_nvm: assert property (p_nvm)
    else $error("saved level is not the present output");

endmodule : acoh_handler

/* File: acoh_host.sv */
// host model: sends command strings, collects the handler's replies
// assumes the handler's command link on clk; tx_ready may stall
module acoh_host
  import acoh_pkg::*;
(
  // clock
  input  wire logic clk,
  // command link
  output acoh_char_t rx_char,
  input  acoh_char_t tx_char,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic  slow = 1'b0;
  string rsp;
  initial rx_char = '0;
  initial tx_ready = 1'b1;
  ////////////////////////////////////////
  // accept every cycle, or every other one when slow
  always @(posedge clk) #1 tx_ready = slow ? ~tx_ready : 1'b1;

  // one character a cycle, CR closes the frame, then the line is released
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk);
      #1 rx_char = {1'b1, (i < s.len()) ? s[i] : CH_CR};
    end
    @(posedge clk);
    #1 rx_char = {1'b0, ~rx_char.data};
  endtask : send

  // gather a reply up to its CR; a T marks that none came in time
  task automatic get(input int lim);
    rsp = "";
    repeat (lim)
    begin
      @(posedge clk);
      if (tx_char.valid === 1'b1 && tx_ready === 1'b1)
      begin
        if (tx_char.data === CH_CR)
          return;
        rsp = {rsp, string'(tx_char.data)};
      end
    end
    rsp = {rsp, "T"};
  endtask : get
endmodule : acoh_host

/* File: test_ascii_output_command_handler.sv */
// testbench for the command handler, single-port and four-port builds, short watchdog unit
// assumes acoh_host.sv stands for the host computer
module test_ascii_output_command_handler;
  timeunit 1ns;
  timeprecision 100ps;
  import acoh_pkg::*;
  logic             clk = 0, resetn = 0, pwr_wd_fail = 0;
  acoh_char_t       rx_char, tx_char;
  logic             tx_ready, cal20_store, host_fail;
  acoh_ao_t         ao_write = '0;
  logic [11:0]      save_lvl;
  logic [3:0][11:0] out_level;
  acoh_nvm_t        nvm_save;
  acoh_char_t       rx4, tx4;
  logic             rdy4;
  logic [3:0][11:0] lvl4;
  int               num_errors = 0, n_checks = 0, n_cal = 0;

  acoh_host h (.clk(clk), .rx_char(rx_char), .tx_char(tx_char), .tx_ready(tx_ready));
  acoh_handler #(.WD_UNIT_CYC(4)) uut (.clk(clk), .resetn(resetn), .rx_char(rx_char),
    .tx_char(tx_char), .tx_ready(tx_ready), .my_addr(8'h06), .pwr_wd_fail(pwr_wd_fail),
    .ao_write(ao_write), .est_current(12'hABC), .power_on_level(12'h3F0),
    .out_level(out_level), .cal20_store(cal20_store), .nvm_save(nvm_save),
    .host_fail(host_fail));
  // four-port build at address 08, power-on level at bipolar zero
  acoh_host h4 (.clk(clk), .rx_char(rx4), .tx_char(tx4), .tx_ready(rdy4));
  acoh_handler #(.NUM_PORTS(4), .WD_UNIT_CYC(4)) uut4 (.clk(clk), .resetn(resetn),
    .rx_char(rx4), .tx_char(tx4), .tx_ready(rdy4), .my_addr(8'h08), .pwr_wd_fail(1'b0),
    .ao_write(ao_write), .est_current(12'h000), .power_on_level(12'h800),
    .out_level(lvl4), .cal20_store(), .nvm_save(), .host_fail());
  ////////////////////////////////////////
  // clock, pulse counters, watchdog
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (cal20_store === 1'b1) n_cal++;
    if (nvm_save.wr === 1'b1) save_lvl = nvm_save.level;
  end
  initial
  begin
    #300us num_errors++;
    conclude();
  end
  ////////////////////////////////////////
  task automatic chk(input string seen, input string exp);
    n_checks++;
    if (seen != exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %s want %s", $time, seen, exp);
    end
  endtask : chk
  function automatic string hx(input logic [11:0] v);
    return $sformatf("%h", v);
  endfunction : hx
  task automatic cmd(input string c, input string exp);
    h.send(c);
    h.get(40);
    #2 chk(h.rsp, exp);
  endtask : cmd
  task automatic cmd4(input string c, input string exp);
    h4.send(c);
    h4.get(40);
    #2 chk(h4.rsp, exp);
  endtask : cmd4
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  // scenarios
  task automatic t_readback;
    chk(hx(out_level[0]), "3f0");
    cmd("$066", "!063F0");
    @(posedge clk);
    #1 ao_write = '{1'b1, 2'd0, 12'h123};
    @(posedge clk);
    #1 ao_write.valid = 1'b0;
    cmd("$066", "!06123");
  endtask : t_readback
  task automatic t_trim;
    cmd("$0635F", "!06");
    chk(hx(out_level[0]), "182");
    cmd("$063A1", "!06");
    cmd("$063FF", "!06");
    chk(hx(out_level[0]), "122");
    cmd("$06360", "?06");
    cmd("$063A0", "?06");
    chk(hx(out_level[0]), "122");
  endtask : t_trim
  task automatic t_misc;
    cmd("$061", "!06");
    chk($sformatf("%0d", n_cal), "1");
    cmd("$064", "!06");
    chk(hx(save_lvl), "122");
    h.slow = 1'b1;
    cmd("$068", "!06ABC");
    h.slow = 1'b0;
    cmd("$071", "T");
    pwr_wd_fail = 1'b1;
    cmd("~060", "!0602$#%@~*");
    pwr_wd_fail = 1'b0;
  endtask : t_misc
  task automatic t_wdog;
    cmd("~062FF7FF", "?06");
    cmd("~0621FF7FF", "!06");
    cmd("~063", "!061FF7FF");
    cmd("~060", "!0604$#%@~*");
    repeat (600) @(posedge clk);
    cmd("~**", "T");
    repeat (600) @(posedge clk);
    chk(hx(host_fail), "000");
    cmd("~062101800", "!06");
    repeat (8) @(posedge clk);
    chk(hx(host_fail), "001");
    chk(hx(out_level[0]), "800");
    cmd("~0620017FF", "!06");
    chk(hx(out_level[0]), "122");
  endtask : t_wdog
  task automatic t_lead;
    cmd("~0610A#%@~*", "!06");
    cmd("A066", "!06122");
    cmd("$066", "T");
  endtask : t_lead
  // four-port build: port letter on readback, four failsafe levels
  task automatic t_quad;
    cmd4("$086A", "!08123");
    cmd4("$086C", "!08800");
    cmd4("$086E", "?08");
    cmd4("$086", "?08");
    cmd4("~0820011FF800000FFF", "!08");
    cmd4("~083", "!080011FF800000FFF");
  endtask : t_quad
  ////////////////////////////////////////
  // main sequence: reset for 4 cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_readback();
    t_trim();
    t_misc();
    t_wdog();
    t_lead();
    t_quad();
    conclude();
  end
endmodule : test_ascii_output_command_handler
